// ### logic/ledrc_pkg.sv
/*
 * ledrc_pkg: register map, field positions, reset values and serial
 * framing constants for the led driver control register bank.
 * Assumes one 10 MHz system clock and 8-bit registers.
 */
`default_nettype none
package ledrc_pkg;
   // register addresses
   localparam logic [6:0] REG_CHIP_REVISION  = 7'h00;
   localparam logic [6:0] REG_ENABLE_CONTROL = 7'h01;
   localparam logic [6:0] REG_TRANSIENT_LIM  = 7'h02;
   localparam logic [6:0] REG_CHAN_A_HIGH    = 7'h03;
   // reset values
   localparam logic [7:0] ENABLE_RESET   = 8'h0F;
   localparam logic [7:0] TRANSIENT_RESET = 8'h30;
   localparam logic [7:0] CHAN_A_RESET   = 8'h00;
   localparam logic [7:0] READ_NONE      = 8'h00;
   // enable_control fields
   localparam int GPO_HI        = 7;
   localparam int GPO_LO        = 4;
   localparam int SAVE_DIS_BIT  = 3;
   localparam int FAST_SD_BIT   = 2;
   localparam int MIRROR_BIT    = 1;
   localparam int LED_SUPPLY_BIT = 0;
   // transient_limit_config fields
   localparam int LEVEL_HI      = 6;
   localparam int LEVEL_LO      = 3;
   localparam int LIMIT_C_BIT   = 2;
   localparam int LIMIT_B_BIT   = 1;
   localparam int LIMIT_A_BIT   = 0;
   // channel_a_current_high field
   localparam int CODE_HI       = 1;
   localparam int CODE_LO       = 0;
   // serial command byte layout
   localparam int CMD_WRITE_BIT = 7;
   localparam int CMD_ADDR_HI   = 6;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] ONE_BIT  = 3'h1;
   // synchroniser idle pattern {mosi, cs_n, sclk}: deselected, clock low
   localparam logic [2:0] PIN_IDLE = 3'h2;
endpackage
`default_nettype wire

// ### logic/ledrc_spi_slave.sv
/*
 * ledrc_spi_slave: oversampling serial peripheral interface slave,
 * mode 0, msb first. Delivers whole bytes and shifts out a loaded byte.
 * Assumes the serial clock runs below a quarter of the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ledrc_spi_slave
   import ledrc_pkg::*;
(
   // clock, reset, enable
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // raw pins
   input  wire logic       sclk_pin,
   input  wire logic       cs_n_pin,
   input  wire logic       mosi_pin,
   // byte side
   input  wire logic       tx_load,
   input  wire logic [7:0] tx_byte,
   output logic            byte_valid,
   output logic [7:0]      byte_data,
   output logic            first_byte,
   output logic            sdo,
   output logic            sdo_oe_n
);
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic       sclk_prev_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] tx_r;
   logic       seen_byte_r;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       active;
   logic [7:0] shift_nxt;

   // edge detect on the second synchroniser stage only
   assign sclk_rise = sync2_r[0] & ~sclk_prev_r;
   assign sclk_fall = ~sync2_r[0] & sclk_prev_r;
   assign active    = ~sync2_r[1];
   assign shift_nxt = {shift_r[6:0], sync2_r[2]};

   // two flops per pin: sclk, cs_n, mosi
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_r     <= PIN_IDLE;
         sync2_r     <= PIN_IDLE;
         sclk_prev_r <= 1'b0;
      end else if (ce) begin
         sync1_r     <= {mosi_pin, cs_n_pin, sclk_pin};
         sync2_r     <= sync1_r;
         sclk_prev_r <= sync2_r[0];
      end
   end

   // receive on rising edges
   always_ff @(posedge clk) begin
      if (rst) begin
         bit_cnt_r   <= 3'h0;
         shift_r     <= 8'h00;
         byte_valid  <= 1'b0;
         byte_data   <= 8'h00;
         first_byte  <= 1'b0;
         seen_byte_r <= 1'b0;
      end else if (ce) begin
         byte_valid <= 1'b0;
         if (!active) begin
            bit_cnt_r   <= 3'h0;
            seen_byte_r <= 1'b0;
         end else if (sclk_rise) begin
            shift_r   <= shift_nxt;
            bit_cnt_r <= bit_cnt_r + ONE_BIT;
            if (bit_cnt_r == LAST_BIT) begin
               byte_valid  <= 1'b1;
               byte_data   <= shift_nxt;
               first_byte  <= ~seen_byte_r;
               seen_byte_r <= 1'b1;
            end
         end
      end
   end

   // transmit on falling edges, released while deselected
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_r     <= 8'h00;
         sdo      <= 1'b0;
         sdo_oe_n <= 1'b1;
      end else if (ce) begin
         if (!active) begin
            sdo_oe_n <= 1'b1;
            tx_r     <= 8'h00;
         end else if (tx_load) begin
            tx_r <= tx_byte;
         end else if (sclk_fall) begin
            sdo      <= tx_r[7];
            tx_r     <= {tx_r[6:0], 1'b0};
            sdo_oe_n <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### logic/ledrc_regs.sv
/*
 * ledrc_regs: the first four control and status registers of the led
 * driver, reached over the serial peripheral interface.
 * Assumes the fault and power request pins are asynchronous levels.
 */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Address 0x00 is an 8-bit read-only word: device code on top, revision code below.
// - The enable register lives at 0x01, is read/write and resets to 0x0F.
// - Enable bits 7:4 are user outputs resetting to zero, bit 1 mirror supply and bit 0 led supply reset to one.
// - Enable bit 3 set turns off the led supply light-load power-save mode, reset one.
// - Enable bit 2, reset one, requests fast shutdown that acts only while a fault is present.
// - The transient limit register lives at 0x02, is read/write, resets to 0x30, with bit 7 unused.
// - Bits 6:3 hold the limit level, reset 0110, codes rising from lowest to highest current.
// - Bit 2, reset zero, enables the transient limit on channel c.
// - Bit 1, reset zero, enables the transient limit on channel b.
// - Bit 0, reset zero, enables the transient limit on channel a.
// - Channel a current high byte lives at 0x03, all eight bits read/write, reset 0x00.
// - Only its two low bits drive the top of the ten-bit channel a current code.
// - The mirror supply bit is writable, cleared on any fault and cleared when the power request pin rises.
module ledrc_regs
   import ledrc_pkg::*;
#(
   parameter logic [3:0] DEVICE_CODE   = 4'h5, // arbitrary value
   parameter logic [3:0] REVISION_CODE = 4'h1  // arbitrary value
)(
   // clock, reset, enable
   input  wire logic       REF_CLK,
   input  wire logic       RST,
   input  wire logic       CE,
   // serial peripheral interface
   input  wire logic       SCLK,
   input  wire logic       CS_N,
   input  wire logic       MOSI,
   output logic            MISO,
   output logic            MISO_OE_N,
   // status pins
   input  wire logic       FAULT,
   input  wire logic       POWER_REQUEST_PIN,
   // enable controls
   output logic [3:0]      USER_GENERAL_OUTPUTS,
   output logic            LED_SUPPLY_SAVE_DISABLE,
   output logic            FAST_SHUTDOWN,
   output logic            MIRROR_ARRAY_SUPPLY_ON,
   output logic            LED_SUPPLY_ON,
   // transient limit controls
   output logic [3:0]      TRANSIENT_LIMIT_LEVEL,
   output logic            LIMIT_ON_CHANNEL_C,
   output logic            LIMIT_ON_CHANNEL_B,
   output logic            LIMIT_ON_CHANNEL_A,
   // channel a current code top bits
   output logic [1:0]      CHANNEL_A_CURRENT_CODE_HIGH
);
   logic [7:0] enable_r;
   logic [7:0] enable_nxt;
   logic [7:0] limit_r;
   logic [7:0] chan_a_r;
   logic       fast_r;
   logic [1:0] pin_s1_r;
   logic [1:0] pin_s2_r;
   logic       pwr_prev_r;
   logic [6:0] addr_r;
   logic       wr_flag_r;
   logic       byte_valid;
   logic [7:0] byte_data;
   logic       first_byte;
   logic       cmd_stb;
   logic       wr_stb;
   logic [6:0] cmd_addr;
   logic [7:0] rd_data;
   logic       fault_s;
   logic       pwr_rise;
   logic       wr_enable;
   logic       wr_limit;
   logic       wr_chan_a;

   // serial engine
   ledrc_spi_slave u_spi (
      .clk        (REF_CLK),
      .rst        (RST),
      .ce         (CE),
      .sclk_pin   (SCLK),
      .cs_n_pin   (CS_N),
      .mosi_pin   (MOSI),
      .tx_load    (cmd_stb),
      .tx_byte    (rd_data),
      .byte_valid (byte_valid),
      .byte_data  (byte_data),
      .first_byte (first_byte),
      .sdo        (MISO),
      .sdo_oe_n   (MISO_OE_N)
   );

   // command and write decode
   assign cmd_stb   = byte_valid & first_byte;
   assign wr_stb    = byte_valid & ~first_byte & wr_flag_r;
   assign cmd_addr  = byte_data[CMD_ADDR_HI:0];
   assign wr_enable = wr_stb & (addr_r == REG_ENABLE_CONTROL);
   assign wr_limit  = wr_stb & (addr_r == REG_TRANSIENT_LIM);
   assign wr_chan_a = wr_stb & (addr_r == REG_CHAN_A_HIGH);
   assign fault_s   = pin_s2_r[0];
   assign pwr_rise  = pin_s2_r[1] & ~pwr_prev_r;

   // read mux; the revision word is constant, unmapped reads give zero
   assign rd_data = (cmd_addr == REG_CHIP_REVISION)  ? {DEVICE_CODE, REVISION_CODE} :
                    (cmd_addr == REG_ENABLE_CONTROL) ? enable_r :
                    (cmd_addr == REG_TRANSIENT_LIM)  ? limit_r :
                    (cmd_addr == REG_CHAN_A_HIGH)    ? chan_a_r : READ_NONE;

   // mirror supply bit: fault and power request rise clear it over a write
   always_comb begin
      enable_nxt = wr_enable ? byte_data : enable_r;
      if (fault_s || pwr_rise) begin
         enable_nxt[MIRROR_BIT] = 1'b0;
      end
   end

   // pin synchronisers and command capture
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         pin_s1_r   <= 2'h0;
         pin_s2_r   <= 2'h0;
         pwr_prev_r <= 1'b0;
         addr_r     <= 7'h00;
         wr_flag_r  <= 1'b0;
      end else if (CE) begin
         pin_s1_r   <= {POWER_REQUEST_PIN, FAULT};
         pin_s2_r   <= pin_s1_r;
         pwr_prev_r <= pin_s2_r[1];
         if (cmd_stb) begin
            addr_r    <= cmd_addr;
            wr_flag_r <= byte_data[CMD_WRITE_BIT];
         end
      end
   end

   // register storage
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         enable_r <= ENABLE_RESET;
         limit_r  <= TRANSIENT_RESET;
         chan_a_r <= CHAN_A_RESET;
         fast_r   <= 1'b0;
      end else if (CE) begin
         enable_r <= enable_nxt;
         fast_r   <= enable_r[FAST_SD_BIT] & fault_s;
         if (wr_limit) begin
            limit_r <= byte_data;
         end
         if (wr_chan_a) begin
            chan_a_r <= byte_data;
         end
      end
   end

   // outputs straight from register bits, fast shutdown from its fault-gated flop fast_r
   assign USER_GENERAL_OUTPUTS        = enable_r[GPO_HI:GPO_LO];
   assign LED_SUPPLY_SAVE_DISABLE     = enable_r[SAVE_DIS_BIT];
   assign FAST_SHUTDOWN               = fast_r;
   assign MIRROR_ARRAY_SUPPLY_ON      = enable_r[MIRROR_BIT];
   assign LED_SUPPLY_ON               = enable_r[LED_SUPPLY_BIT];
   assign TRANSIENT_LIMIT_LEVEL       = limit_r[LEVEL_HI:LEVEL_LO];
   assign LIMIT_ON_CHANNEL_C          = limit_r[LIMIT_C_BIT];
   assign LIMIT_ON_CHANNEL_B          = limit_r[LIMIT_B_BIT];
   assign LIMIT_ON_CHANNEL_A          = limit_r[LIMIT_A_BIT];
   assign CHANNEL_A_CURRENT_CODE_HIGH = chan_a_r[CODE_HI:CODE_LO];

   // checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   property p_rev_read;
      CE && cmd_stb && cmd_addr == REG_CHIP_REVISION |=> u_spi.tx_r == {DEVICE_CODE, REVISION_CODE};
   endproperty
   a_rev_read: assert property (p_rev_read) else $error("revision word wrong");

   property p_reset_values;
      $fell(RST) |-> enable_r == ENABLE_RESET && limit_r == TRANSIENT_RESET && chan_a_r == CHAN_A_RESET;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("bad reset value");

   property p_enable_write;
      CE && wr_enable && !fault_s && !pwr_rise |=> enable_r == $past(byte_data);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write lost");

   property p_save_disable;
      CE && wr_enable |=> LED_SUPPLY_SAVE_DISABLE == $past(byte_data[SAVE_DIS_BIT]) &&
         USER_GENERAL_OUTPUTS == $past(byte_data[GPO_HI:GPO_LO]);
   endproperty
   a_save_disable: assert property (p_save_disable) else $error("enable outputs off");

   property p_fast_only_fault;
      CE ##1 FAST_SHUTDOWN |-> $past(fault_s) && $past(enable_r[FAST_SD_BIT]);
   endproperty
   a_fast_only_fault: assert property (p_fast_only_fault) else $error("fast shutdown without fault");

   property p_limit_write;
      CE && wr_limit |=> limit_r == $past(byte_data) ##0 TRANSIENT_LIMIT_LEVEL == $past(byte_data[LEVEL_HI:LEVEL_LO]);
   endproperty
   a_limit_write: assert property (p_limit_write) else $error("limit write lost");

   property p_limit_bits;
      CE && wr_limit |=>
         {LIMIT_ON_CHANNEL_C, LIMIT_ON_CHANNEL_B, LIMIT_ON_CHANNEL_A} == $past(byte_data[LIMIT_C_BIT:LIMIT_A_BIT]);
   endproperty
   a_limit_bits: assert property (p_limit_bits) else $error("channel limit mismatch");

   property p_chan_write;
      CE && wr_chan_a |=> chan_a_r == $past(byte_data) &&
         CHANNEL_A_CURRENT_CODE_HIGH == $past(byte_data[CODE_HI:CODE_LO]);
   endproperty
   a_chan_write: assert property (p_chan_write) else $error("channel a write lost");

   property p_mirror_clear;
      CE && (fault_s || pwr_rise) |=> !MIRROR_ARRAY_SUPPLY_ON;
   endproperty
   a_mirror_clear: assert property (p_mirror_clear) else $error("mirror supply not cleared");

   property p_rev_write_ignored;
      CE && wr_stb && addr_r == REG_CHIP_REVISION && !fault_s && !pwr_rise |=>
         $stable(enable_r) && $stable(limit_r) && $stable(chan_a_r);
   endproperty
   a_rev_write_ignored: assert property (p_rev_write_ignored) else $error("revision write had effect");

   c_enable_write: cover property (CE && wr_enable);
   c_fault_clear:  cover property (CE && fault_s && MIRROR_ARRAY_SUPPLY_ON);
   c_read_limit:   cover property (cmd_stb && cmd_addr == REG_TRANSIENT_LIM && !byte_data[CMD_WRITE_BIT]);
   c_fast_active:  cover property (FAST_SHUTDOWN);
endmodule
`default_nettype wire

// ### bench/ledrc_regs_tb.sv
/*
 * ledrc_regs_tb: self-checking bench for the led driver control registers,
 * driving the serial interface, fault and power request pins directly.
 * Assumes the ledrc_pkg package and the ledrc_regs design are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module ledrc_regs_tb;
   import ledrc_pkg::*;
   // arbitrary identity values handed to the design
   localparam logic [3:0] DEV_CODE = 4'hA;
   localparam logic [3:0] REV_CODE = 4'h6;
   logic       REF_CLK, RST, CE, SCLK, CS_N, MOSI, FAULT, POWER_REQUEST_PIN;
   logic       MISO, MISO_OE_N, LED_SUPPLY_SAVE_DISABLE, FAST_SHUTDOWN;
   logic       MIRROR_ARRAY_SUPPLY_ON, LED_SUPPLY_ON;
   logic       LIMIT_ON_CHANNEL_C, LIMIT_ON_CHANNEL_B, LIMIT_ON_CHANNEL_A;
   logic [3:0] USER_GENERAL_OUTPUTS, TRANSIENT_LIMIT_LEVEL;
   logic [1:0] CHANNEL_A_CURRENT_CODE_HIGH;
   logic [7:0] rd;
   logic       oe_low;
   int         n_mismatch = 0;
   int         checked    = 0;

   ledrc_regs #(.DEVICE_CODE(DEV_CODE), .REVISION_CODE(REV_CODE)) dut (
      .REF_CLK(REF_CLK), .RST(RST), .CE(CE), .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI),
      .MISO(MISO), .MISO_OE_N(MISO_OE_N), .FAULT(FAULT), .POWER_REQUEST_PIN(POWER_REQUEST_PIN),
      .USER_GENERAL_OUTPUTS(USER_GENERAL_OUTPUTS), .LED_SUPPLY_SAVE_DISABLE(LED_SUPPLY_SAVE_DISABLE),
      .FAST_SHUTDOWN(FAST_SHUTDOWN), .MIRROR_ARRAY_SUPPLY_ON(MIRROR_ARRAY_SUPPLY_ON),
      .LED_SUPPLY_ON(LED_SUPPLY_ON), .TRANSIENT_LIMIT_LEVEL(TRANSIENT_LIMIT_LEVEL),
      .LIMIT_ON_CHANNEL_C(LIMIT_ON_CHANNEL_C), .LIMIT_ON_CHANNEL_B(LIMIT_ON_CHANNEL_B),
      .LIMIT_ON_CHANNEL_A(LIMIT_ON_CHANNEL_A), .CHANNEL_A_CURRENT_CODE_HIGH(CHANNEL_A_CURRENT_CODE_HIGH)
   );

   // 10 MHz system clock
   initial begin
      REF_CLK = 1'b0;
      forever #50 REF_CLK = ~REF_CLK;
   end

   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic stop_test();
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // one mode 0 frame: command byte then data byte, read bits taken before each rise
   task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] q);
      logic [15:0] w;
      w = {cmd, dat};
      q = 8'h00;
      oe_low = 1'b1;
      CS_N = 1'b0;
      repeat (4) @(negedge REF_CLK);
      for (int i = 15; i >= 0; i--) begin
         MOSI = w[i];
         repeat (5) @(negedge REF_CLK);
         if (i < 8) begin
            q[i] = MISO;
            oe_low = oe_low & ~MISO_OE_N;
         end
         SCLK = 1'b1;
         repeat (5) @(negedge REF_CLK);
         SCLK = 1'b0;
      end
      repeat (6) @(negedge REF_CLK);
      CS_N = 1'b1;
      repeat (5) @(negedge REF_CLK);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      frame({1'b1, a}, d, q);
   endtask

   task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
      frame({1'b0, a}, 8'h00, rd);
      check(rd, exp);
      // data pin driven while read bits shift, released after the frame
      check({6'h00, oe_low, MISO_OE_N}, 8'h03);
   endtask

   // enable outputs gathered into register order
   function automatic logic [7:0] en_pins();
      return {USER_GENERAL_OUTPUTS, LED_SUPPLY_SAVE_DISABLE, FAST_SHUTDOWN, MIRROR_ARRAY_SUPPLY_ON, LED_SUPPLY_ON};
   endfunction

   // pin level change, then settle past the synchronisers
   task automatic pins(input logic f, input logic p);
      FAULT = f;
      POWER_REQUEST_PIN = p;
      repeat (8) @(negedge REF_CLK);
   endtask

   // watchdog against a hung sequence
   initial begin
      repeat (20000) @(posedge REF_CLK);
      n_mismatch++;
      stop_test();
   end

   // main sequence
   initial begin
      RST = 1'b1; CE = 1'b1; SCLK = 1'b0; CS_N = 1'b1; MOSI = 1'b0;
      FAULT = 1'b0; POWER_REQUEST_PIN = 1'b0;
      repeat (10) @(negedge REF_CLK);
      RST = 1'b0;
      repeat (5) @(negedge REF_CLK);
      // reset values at the pins and through reads
      check(en_pins() & 8'hFB, 8'h0B);
      check({1'b0, TRANSIENT_LIMIT_LEVEL, LIMIT_ON_CHANNEL_C, LIMIT_ON_CHANNEL_B, LIMIT_ON_CHANNEL_A},
            8'h30);
      check({6'h00, CHANNEL_A_CURRENT_CODE_HIGH}, 8'h00);
      rdchk(REG_CHIP_REVISION, {DEV_CODE, REV_CODE});
      rdchk(REG_ENABLE_CONTROL, 8'h0F);
      rdchk(REG_TRANSIENT_LIM, 8'h30);
      rdchk(REG_CHAN_A_HIGH, 8'h00);
      // write to the read-only word is ignored
      wr(REG_CHIP_REVISION, 8'hFF);
      rdchk(REG_CHIP_REVISION, {DEV_CODE, REV_CODE});
      // enable fields, both polarities of every bit
      wr(REG_ENABLE_CONTROL, 8'hA5);
      check(en_pins(), 8'hA1);
      rdchk(REG_ENABLE_CONTROL, 8'hA5);
      wr(REG_ENABLE_CONTROL, 8'h5A);
      check(en_pins(), 8'h5A);
      rdchk(REG_ENABLE_CONTROL, 8'h5A);
      // every limit level code with varying channel enables
      for (int i = 0; i < 16; i++) begin
         wr(REG_TRANSIENT_LIM, {i[0], i[3:0], i[2:0]});
         check({1'b0, TRANSIENT_LIMIT_LEVEL, LIMIT_ON_CHANNEL_C, LIMIT_ON_CHANNEL_B, LIMIT_ON_CHANNEL_A},
               {1'b0, i[3:0], i[2:0]});
         rdchk(REG_TRANSIENT_LIM, {i[0], i[3:0], i[2:0]});
      end
      // channel a high byte, all bits stored, two drive the code
      wr(REG_CHAN_A_HIGH, 8'hFD);
      check({6'h00, CHANNEL_A_CURRENT_CODE_HIGH}, 8'h01);
      rdchk(REG_CHAN_A_HIGH, 8'hFD);
      wr(REG_CHAN_A_HIGH, 8'h02);
      check({6'h00, CHANNEL_A_CURRENT_CODE_HIGH}, 8'h02);
      // fast shutdown acts only while a fault is present
      wr(REG_ENABLE_CONTROL, 8'h04);
      check({7'h00, FAST_SHUTDOWN}, 8'h00);
      pins(1'b1, 1'b0);
      check({7'h00, FAST_SHUTDOWN}, 8'h01);
      pins(1'b0, 1'b0);
      check({7'h00, FAST_SHUTDOWN}, 8'h00);
      // a fault clears the mirror bit and beats later writes
      wr(REG_ENABLE_CONTROL, 8'h02);
      check(en_pins(), 8'h02);
      pins(1'b1, 1'b0);
      check(en_pins(), 8'h00);
      wr(REG_ENABLE_CONTROL, 8'h02);
      rdchk(REG_ENABLE_CONTROL, 8'h00);
      pins(1'b0, 1'b0);
      // power request rise clears the mirror bit
      wr(REG_ENABLE_CONTROL, 8'h03);
      pins(1'b0, 1'b1);
      check(en_pins(), 8'h01);
      rdchk(REG_ENABLE_CONTROL, 8'h01);
      // unmapped place reads as zero
      wr(7'h7F, 8'hAA);
      rdchk(7'h7F, READ_NONE);
      // both status pins back to low before the clock enable test
      pins(1'b0, 1'b0);
      // clock enable low freezes the pin path, the fault acts once enabled; then a second reset in mid-run restores defaults
      wr(REG_ENABLE_CONTROL, 8'h02);
      CE = 1'b0;
      pins(1'b1, 1'b0);
      check(en_pins(), 8'h02);
      CE = 1'b1;
      pins(1'b1, 1'b0);
      check(en_pins(), 8'h00);
      pins(1'b0, 1'b0);
      wr(REG_ENABLE_CONTROL, 8'hF0);
      RST = 1'b1;
      repeat (10) @(negedge REF_CLK);
      RST = 1'b0;
      repeat (5) @(negedge REF_CLK);
      rdchk(REG_ENABLE_CONTROL, ENABLE_RESET);
      rdchk(REG_TRANSIENT_LIM, TRANSIENT_RESET);
      stop_test();
   end
endmodule
`default_nettype wire
